// ===== rtl/vpu_pkg.sv
// Package for the video pixel input unpacker: register map, modes, types
package vpu_pkg;
    localparam logic [2:0] PIX_FMT_16 = 3'h5;
    localparam logic [2:0] PIX_FMT_18 = 3'h6;
    localparam logic [2:0] PIX_FMT_24 = 3'h7;
    localparam logic [5:0] DT_PACKED16 = 6'h0e;
    localparam logic [5:0] DT_PACKED18 = 6'h1e;
    localparam logic [5:0] DT_LOOSE18 = 6'h2e;
    localparam int PAYLOAD_BYTES_16 = 2;
    localparam int PAYLOAD_BYTES_18 = 9;
    localparam int PAYLOAD_BYTES_LOOSE = 3;
    localparam int PIXELS_PER_GROUP_18 = 4;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LINE_WIDTH = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PIXEL_COUNT = 8'h0c;
    localparam logic [7:0] REG_DROP_COUNT = 8'h10;
    // Control field positions
    localparam int CTRL_FMT_LSB = 0;
    localparam int CTRL_WIDE_BIT = 4;
    localparam int CTRL_DITHER_BIT = 5;
    localparam int CTRL_BYPASS_BIT = 6;
    localparam int CTRL_PKT_BIT = 7;
    localparam int CTRL_DT_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] LINE_WIDTH_RESET = 16'h0140;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic full_depth;
    } vpu_pixel_type;

    typedef enum {
        VPU_PAR_OFF,
        VPU_PAR_16,
        VPU_PAR_18,
        VPU_PAR_24_18,
        VPU_PAR_24_FULL
    } vpu_par_mode_type;
endpackage

// ===== rtl/vpu_unpacker.sv
// Video pixel input unpacker: parallel RGB capture and packet payload unpacking
`timescale 1ns/1ns
// What this block does
// (RULE1) Format 101 accepts 16-bit parallel pixels
// (RULE2) Format 110 accepts 18-bit parallel pixels
// (RULE3) 24-bit bus needs format 111 and wide-bus
// (RULE4) Full colour needs 111, wide, dither, bypass
// (RULE5) 16/18-bit capture follows pixel clock and syncs
// (RULE6) 24-bit capture qualified by data enable
// (RULE7) 16-bit pixel is 5-6-5 from bits 15..0
// (RULE8) 18-bit pixel is 6-6-6 from bits 17..0
// (RULE9) 24-bit pixel is 8-8-8 from bits 23..0
// (RULE10) Full mode carries one 24-bit pixel per transfer
// (RULE11) Type 0Eh is 16-bit packed long packet
// (RULE12) 0Eh unpacks two bytes as 5-6-5
// (RULE13) 1Eh unpacks 6-6-6, nine bytes per four pixels
// (RULE14) Host pads packed 18-bit lines to four pixels
// (RULE15) Fill pixels past line width are dropped
// (RULE16) 2Eh uses byte bits 7..2, three bytes per pixel
// (RULE17) Host keeps 16-bit lines whole two-byte units
// (RULE18) Host keeps loose lines whole three-byte units
// (RULE19) Host streams packet video continuously
// (RULE20) Unknown formats or types are discarded
module vpu_unpacker #(
    parameter int LINE_WIDTH_BITS = 16
)(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Parallel video pins
    input wire logic pixel_clock,
    input wire logic vsync,
    input wire logic hsync,
    input wire logic data_enable,
    input wire logic [23:0] video_bus,
    // Packet payload byte stream, same clock domain
    input wire logic pkt_start,
    input wire logic pkt_byte_valid,
    input wire logic [7:0] pkt_byte,
    // Pixels toward frame memory
    output logic pix_valid,
    output vpu_pkg::vpu_pixel_type pix_out,
    output logic pix_line_start,
    output logic pix_frame_start
);
    // Column counter and width compare are built for 4 to 16 bits
    if (LINE_WIDTH_BITS < 4 || LINE_WIDTH_BITS > 16)
    begin : width_check
        $error("LINE_WIDTH_BITS must be 4..16");
    end

    logic [31:0] ctrl_reg;
    logic [15:0] line_width_reg;
    logic [31:0] pixel_count_reg;
    logic [31:0] drop_count_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;

    // AHB-Lite: zero wait states, OKAY always
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_reg <= hsel && htrans == vpu_pkg::HTRANS_NONSEQ && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg <= vpu_pkg::CTRL_RESET;
            line_width_reg <= vpu_pkg::LINE_WIDTH_RESET;
        end
        else if (wr_pend_reg)
        begin
            if (wr_addr_reg == vpu_pkg::REG_CTRL)
                ctrl_reg <= {18'h0, hwdata[13:0]};
            else if (wr_addr_reg == vpu_pkg::REG_LINE_WIDTH)
                line_width_reg <= hwdata[15:0];
        end
    end

    logic vsync_s;
    logic hsync_s;
    logic [31:0] rd_mux;
    always_comb
    begin
        case (haddr)
            vpu_pkg::REG_CTRL: rd_mux = ctrl_reg;
            vpu_pkg::REG_LINE_WIDTH: rd_mux = {16'h0000, line_width_reg};
            vpu_pkg::REG_STATUS: rd_mux = {29'h0, vsync_s, hsync_s, pix_valid};
            vpu_pkg::REG_PIXEL_COUNT: rd_mux = pixel_count_reg;
            vpu_pkg::REG_DROP_COUNT: rd_mux = drop_count_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans == vpu_pkg::HTRANS_NONSEQ && !hwrite)
            hrdata <= rd_mux;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Pin synchronisers; data is taken on the synchronised edge, so the host
    // must hold the bus a full pixel clock period (slow link vs hclk)
    logic [1:0] pclk_sync;
    logic [1:0] vs_sync;
    logic [1:0] hs_sync;
    logic [1:0] de_sync;
    logic [23:0] bus_m;
    logic [23:0] bus_s;
    logic pclk_prev;
    logic vs_prev;
    logic hs_prev;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pclk_sync <= 2'h0;
            vs_sync <= 2'h0;
            hs_sync <= 2'h0;
            de_sync <= 2'h0;
            bus_m <= 24'h000000;
            bus_s <= 24'h000000;
            pclk_prev <= 1'b0;
        end
        else
        begin
            pclk_sync <= {pclk_sync[0], pixel_clock};
            vs_sync <= {vs_sync[0], vsync};
            hs_sync <= {hs_sync[0], hsync};
            de_sync <= {de_sync[0], data_enable};
            bus_m <= video_bus;
            bus_s <= bus_m;
            pclk_prev <= pclk_sync[1];
        end
    end
    assign vsync_s = vs_sync[1];
    assign hsync_s = hs_sync[1];
    wire pclk_rise = pclk_sync[1] && !pclk_prev;

    // Parallel mode decode
    function automatic vpu_pkg::vpu_par_mode_type decode_par(input logic [31:0] c);
        logic [2:0] f;
        f = c[vpu_pkg::CTRL_FMT_LSB +: 3];
        decode_par = vpu_pkg::VPU_PAR_OFF;
        if (f == vpu_pkg::PIX_FMT_16)
            decode_par = vpu_pkg::VPU_PAR_16;
        else if (f == vpu_pkg::PIX_FMT_18)
            decode_par = vpu_pkg::VPU_PAR_18;
        else if (f == vpu_pkg::PIX_FMT_24 && c[vpu_pkg::CTRL_WIDE_BIT])
            decode_par = (c[vpu_pkg::CTRL_DITHER_BIT] && c[vpu_pkg::CTRL_BYPASS_BIT]) ?
                vpu_pkg::VPU_PAR_24_FULL : vpu_pkg::VPU_PAR_24_18;
    endfunction

    // (RULE3) (RULE4) Mode selection
    vpu_pkg::vpu_par_mode_type par_mode;
    assign par_mode = decode_par(ctrl_reg);
    wire pkt_mode = ctrl_reg[vpu_pkg::CTRL_PKT_BIT];
    wire [5:0] dt = ctrl_reg[vpu_pkg::CTRL_DT_LSB +: 6];

    logic par_ok;
    vpu_pkg::vpu_pixel_type par_pix;
    always_comb
    begin
        par_pix = '0;
        par_ok = 1'b0;
        case (par_mode)
            // (RULE1) (RULE5) (RULE7) 5-6-5 from low 16 bits
            vpu_pkg::VPU_PAR_16:
            begin
                par_ok = 1'b1;
                par_pix.red = {bus_s[15:11], 3'h0};
                par_pix.green = {bus_s[10:5], 2'h0};
                par_pix.blue = {bus_s[4:0], 3'h0};
            end
            // (RULE2) (RULE8) 6-6-6 from low 18 bits
            vpu_pkg::VPU_PAR_18:
            begin
                par_ok = 1'b1;
                par_pix.red = {bus_s[17:12], 2'h0};
                par_pix.green = {bus_s[11:6], 2'h0};
                par_pix.blue = {bus_s[5:0], 2'h0};
            end
            // (RULE6) (RULE9) 8-8-8, 18-bit depth kept
            vpu_pkg::VPU_PAR_24_18:
            begin
                par_ok = de_sync[1];
                par_pix.red = {bus_s[23:18], 2'h0};
                par_pix.green = {bus_s[15:10], 2'h0};
                par_pix.blue = {bus_s[7:2], 2'h0};
            end
            // (RULE6) (RULE10) one full 24-bit pixel per transfer
            vpu_pkg::VPU_PAR_24_FULL:
            begin
                par_ok = de_sync[1];
                par_pix.red = bus_s[23:16];
                par_pix.green = bus_s[15:8];
                par_pix.blue = bus_s[7:0];
                par_pix.full_depth = 1'b1;
            end
            // (RULE20) unknown parallel format discarded
            default: par_ok = 1'b0;
        endcase
    end

    // Packet byte gathering; a group holds up to nine bytes
    logic [71:0] grp_reg;
    logic [3:0] byte_cnt_reg;
    logic [LINE_WIDTH_BITS-1:0] col_reg;
    logic [3:0] grp_len;
    always_comb
    begin
        case (dt)
            vpu_pkg::DT_PACKED16: grp_len = 4'(vpu_pkg::PAYLOAD_BYTES_16);
            vpu_pkg::DT_PACKED18: grp_len = 4'(vpu_pkg::PAYLOAD_BYTES_18);
            vpu_pkg::DT_LOOSE18: grp_len = 4'(vpu_pkg::PAYLOAD_BYTES_LOOSE);
            default: grp_len = 4'h0;
        endcase
    end
    // (RULE11) payload bytes only, header and checksum stripped upstream
    wire pkt_take = pkt_mode && pkt_byte_valid && grp_len != 4'h0;
    wire [71:0] grp_now = grp_reg | (72'(pkt_byte) << {byte_cnt_reg, 3'h0});
    wire grp_done = pkt_take && (byte_cnt_reg + 4'h1 == grp_len);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            grp_reg <= '0;
            byte_cnt_reg <= 4'h0;
        end
        else if (pkt_start || grp_done)
        begin
            grp_reg <= '0;
            byte_cnt_reg <= 4'h0;
        end
        else if (pkt_take)
        begin
            grp_reg <= grp_now;
            byte_cnt_reg <= byte_cnt_reg + 4'h1;
        end
    end

    // Unpacked pixels of the finished group; LSB arrives first
    logic [2:0] n_pix;
    logic [17:0] pk [4];
    always_comb
    begin
        n_pix = 3'h0;
        for (int i = 0; i < 4; i++)
            pk[i] = 18'h0;
        case (dt)
            // (RULE12) 5-6-5, green split over two bytes
            vpu_pkg::DT_PACKED16:
            begin
                n_pix = 3'h1;
                pk[0] = {grp_now[4:0], 1'b0, grp_now[10:5], grp_now[15:11], 1'b0};
            end
            // (RULE13) four pixels per nine bytes
            vpu_pkg::DT_PACKED18:
            begin
                n_pix = 3'h4;
                for (int i = 0; i < 4; i++)
                    pk[i] = {grp_now[18*i +: 6], grp_now[18*i+6 +: 6], grp_now[18*i+12 +: 6]};
            end
            // (RULE16) loose: bits 7..2 used, 1..0 ignored
            vpu_pkg::DT_LOOSE18:
            begin
                n_pix = 3'h1;
                pk[0] = {grp_now[7:2], grp_now[15:10], grp_now[23:18]};
            end
            // (RULE20) unknown data type discarded
            default: n_pix = 3'h0;
        endcase
    end

    // Serialise a packed18 group over four cycles; the source must leave
    // three idle cycles between group completions
    logic [71:0] hold_reg;
    logic [2:0] left_reg;
    logic [1:0] idx_reg;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hold_reg <= '0;
            left_reg <= 3'h0;
            idx_reg <= 2'h0;
        end
        else if (grp_done && n_pix != 3'h0)
        begin
            hold_reg <= {pk[3], pk[2], pk[1], pk[0]} << 0;
            left_reg <= n_pix;
            idx_reg <= 2'h0;
        end
        else if (left_reg != 3'h0)
        begin
            left_reg <= left_reg - 3'h1;
            idx_reg <= idx_reg + 2'h1;
        end
    end
    wire [17:0] pkt_cur = hold_reg[18*idx_reg +: 18];
    wire pkt_emit = left_reg != 3'h0;
    // (RULE15) fill pixels past the active width dropped
    wire pkt_keep = 16'(col_reg) < line_width_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            col_reg <= '0;
        else if (pkt_start)
            col_reg <= '0;
        else if (pkt_emit && pkt_keep)
            col_reg <= col_reg + 1'b1;
    end

    // Output to frame memory, written in step with scanning
    wire par_take = !pkt_mode && pclk_rise && par_ok;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pix_valid <= 1'b0;
            pix_out <= '0;
            pix_line_start <= 1'b0;
            pix_frame_start <= 1'b0;
            vs_prev <= 1'b0;
            hs_prev <= 1'b0;
        end
        else
        begin
            vs_prev <= vsync_s;
            hs_prev <= hsync_s;
            pix_line_start <= !pkt_mode && hsync_s && !hs_prev;
            pix_frame_start <= !pkt_mode && vsync_s && !vs_prev;
            pix_valid <= par_take || (pkt_mode && pkt_emit && pkt_keep);
            if (pkt_mode)
                pix_out <= '{red: {pkt_cur[17:12], 2'h0}, green: {pkt_cur[11:6], 2'h0},
                    blue: {pkt_cur[5:0], 2'h0}, full_depth: 1'b0};
            else
                pix_out <= par_pix;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pixel_count_reg <= 32'h0000_0000;
            drop_count_reg <= 32'h0000_0000;
        end
        else
        begin
            if (par_take || (pkt_mode && pkt_emit && pkt_keep))
                pixel_count_reg <= pixel_count_reg + 32'h1;
            if (pkt_mode && pkt_emit && !pkt_keep)
                drop_count_reg <= drop_count_reg + 32'h1;
        end
    end
endmodule

// ===== tb/vpu_unpacker_properties.sv
// Port-level checker for the pixel unpacker, bound into the design
`timescale 1ns/1ns
module vpu_unpacker_checker (
    // Clock, reset and register bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Video pins and pixel output
    input wire logic vsync,
    input wire logic hsync,
    input wire logic data_enable,
    input wire logic pix_valid,
    input wire vpu_pkg::vpu_pixel_type pix_out,
    input wire logic pix_line_start,
    input wire logic pix_frame_start
);
    logic wr_pend;
    logic [13:0] ctrl_q;
    logic [3:0] de_low;
    logic addr_ok;
    logic mode24;
    logic mode_ok;
    assign addr_ok = hsel && hready && htrans == vpu_pkg::HTRANS_NONSEQ;
    assign mode24 = !ctrl_q[7] && ctrl_q[2:0] == vpu_pkg::PIX_FMT_24 && ctrl_q[4];
    assign mode_ok = ctrl_q[7] ? ctrl_q[13:8] inside {vpu_pkg::DT_PACKED16, vpu_pkg::DT_PACKED18, vpu_pkg::DT_LOOSE18}
        : (ctrl_q[2:0] == vpu_pkg::PIX_FMT_16 || ctrl_q[2:0] == vpu_pkg::PIX_FMT_18 || mode24);

    // Control shadow rebuilt from bus writes; the strobe age saturates
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            ctrl_q <= 14'h0;
            de_low <= 4'hf;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite && haddr == vpu_pkg::REG_CTRL;
            if (wr_pend)
                ctrl_q <= hwdata[13:0];
            de_low <= data_enable ? 4'h0 : (de_low == 4'hf ? de_low : de_low + 4'h1);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    discard_mode_a: assert property (pix_valid |-> $past(mode_ok, 2))
        else $error("pixel in unknown mode");
    full_depth_a: assert property (pix_valid |-> pix_out.full_depth == (mode24 && ctrl_q[6:5] == 2'h3))
        else $error("full depth flag wrong");
    pad_low_a: assert property (pix_valid && !pix_out.full_depth |->
        {pix_out.red[1:0], pix_out.green[1:0], pix_out.blue[1:0]} == 6'h0)
        else $error("six-bit pixel not left aligned");
    pad_five_a: assert property (pix_valid && (ctrl_q[7] ? ctrl_q[13:8] == vpu_pkg::DT_PACKED16
        : ctrl_q[2:0] == vpu_pkg::PIX_FMT_16) |-> {pix_out.red[2:0], pix_out.blue[2:0]} == 6'h0)
        else $error("five-bit field not left aligned");
    enable_gate_a: assert property (pix_valid && mode24 |-> de_low < 4'h8)
        else $error("pixel taken without data enable");
    line_start_a: assert property ($rose(hsync) && !ctrl_q[7] && mode_ok |-> ##[1:6] pix_line_start)
        else $error("line start missing");
    frame_start_a: assert property ($rose(vsync) && !ctrl_q[7] && mode_ok |-> ##[1:6] pix_frame_start)
        else $error("frame start missing");
    unmapped_zero_a: assert property (addr_ok && !hwrite && haddr > vpu_pkg::REG_DROP_COUNT |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_read_a: assert property (addr_ok && !hwrite && haddr == vpu_pkg::REG_CTRL |=> hrdata == {18'h0, ctrl_q})
        else $error("control readback wrong");
endmodule

bind vpu_unpacker vpu_unpacker_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .vsync, .hsync, .data_enable, .pix_valid, .pix_out, .pix_line_start, .pix_frame_start);

// ===== tb/vpu_host_model.sv
// Host display controller model: parallel video pins and packet byte stream
`timescale 1ns/1ns
module vpu_host_model (
    // Clock of the byte stream
    input wire logic hclk,
    // Parallel video pins
    output logic pixel_clock,
    output logic vsync,
    output logic hsync,
    output logic data_enable,
    output logic [23:0] video_bus,
    // Packet payload stream
    output logic pkt_start,
    output logic pkt_byte_valid,
    output logic [7:0] pkt_byte
);
    initial
    begin
        pixel_clock = 1'b0;
        vsync = 1'b0;
        hsync = 1'b0;
        data_enable = 1'b0;
        video_bus = 24'h0;
        pkt_start = 1'b0;
        pkt_byte_valid = 1'b0;
        pkt_byte = 8'h0;
    end

    // Pixel clock runs only inside a frame, period 160 ns
    task pulse;
        #80 pixel_clock = 1'b1;
        #80 pixel_clock = 1'b0;
    endtask

    task send_frame(input logic [23:0] d, input logic de);
        #13 vsync = 1'b1;
        #160 vsync = 1'b0;
        hsync = 1'b1;
        #160 hsync = 1'b0;
        video_bus = d;
        data_enable = de;
        repeat (2) pulse();
        // Released bus shows the inverse so stale data cannot pass
        #80 video_bus = ~d;
        data_enable = 1'b0;
    endtask

    task send_pkt(input logic [71:0] g, input int n);
        @(posedge hclk);
        pkt_start <= 1'b1;
        @(posedge hclk);
        pkt_start <= 1'b0;
        for (int k = 0; k < n; k++)
        begin
            pkt_byte_valid <= 1'b1;
            pkt_byte <= g[8*k+:8];
            @(posedge hclk);
        end
        pkt_byte_valid <= 1'b0;
        pkt_byte <= ~pkt_byte;
        repeat (4) @(posedge hclk);
    endtask
endmodule

// ===== tb/vpu_unpacker_tb.sv
// Self-checking bench for the pixel unpacker
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module vpu_unpacker_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pixel_clock;
    logic vsync;
    logic hsync;
    logic data_enable;
    logic [23:0] video_bus;
    logic pkt_start;
    logic pkt_byte_valid;
    logic [7:0] pkt_byte;
    logic pix_valid;
    logic pix_line_start;
    logic pix_frame_start;
    vpu_pkg::vpu_pixel_type pix_out;
    vpu_pkg::vpu_pixel_type got[$];
    vpu_pkg::vpu_pixel_type exp_q[$];
    logic [31:0] rd;
    logic [31:0] d0;
    int fails = 0;
    int total_checks = 0;
    logic [7:0] pm [8] = '{8'h05, 8'h06, 8'h17, 8'h77, 8'h07, 8'h67, 8'h37, 8'h03};
    logic [5:0] pd [4] = '{vpu_pkg::DT_PACKED16, vpu_pkg::DT_PACKED18, vpu_pkg::DT_LOOSE18, 6'h3e};
    logic [71:0] pg [4] = '{72'hb3d5, 72'h9c5a3fe127b48d6e11, 72'h6db257, 72'h112233};
    int nb [4] = '{2, 9, 3, 3};

    initial forever #10 hclk = ~hclk;

    vpu_unpacker dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .pixel_clock, .vsync, .hsync, .data_enable, .video_bus, .pkt_start, .pkt_byte_valid,
        .pkt_byte, .pix_valid, .pix_out, .pix_line_start, .pix_frame_start);
    vpu_host_model host (.hclk, .pixel_clock, .vsync, .hsync, .data_enable, .video_bus, .pkt_start, .pkt_byte_valid,
        .pkt_byte);

    // Sampled mid-cycle so the registered pixel has settled
    always @(negedge hclk)
        if (pix_valid === 1'b1)
            got.push_back(pix_out);

    task complete_run;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                fails++;
                complete_run();
            end
            @(posedge hclk);
        end
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= vpu_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    function vpu_pkg::vpu_pixel_type px(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b, input logic f);
        px = {r, g, b, f};
    endfunction

    // Two pixels per frame; six-bit and five-bit fields arrive left aligned
    task par_expect(input logic [7:0] c, input logic [23:0] d, input logic de);
        repeat (2)
            if (c[2:0] == vpu_pkg::PIX_FMT_16)
                exp_q.push_back(px({d[15:11], 3'h0}, {d[10:5], 2'h0}, {d[4:0], 3'h0}, 1'b0));
            else if (c[2:0] == vpu_pkg::PIX_FMT_18)
                exp_q.push_back(px({d[17:12], 2'h0}, {d[11:6], 2'h0}, {d[5:0], 2'h0}, 1'b0));
            else if (c[2:0] == vpu_pkg::PIX_FMT_24 && c[4] && de)
                exp_q.push_back(c[6:5] == 2'h3 ? px(d[23:16], d[15:8], d[7:0], 1'b1)
                    : px({d[23:18], 2'h0}, {d[15:10], 2'h0}, {d[7:2], 2'h0}, 1'b0));
    endtask

    task pkt_expect(input logic [5:0] dt, input logic [71:0] g, input int w);
        if (dt == vpu_pkg::DT_PACKED16)
            exp_q.push_back(px({g[4:0], 3'h0}, {g[10:5], 2'h0}, {g[15:11], 3'h0}, 1'b0));
        if (dt == vpu_pkg::DT_LOOSE18)
            exp_q.push_back(px({g[7:2], 2'h0}, {g[15:10], 2'h0}, {g[23:18], 2'h0}, 1'b0));
        if (dt == vpu_pkg::DT_PACKED18)
            for (int i = 0; i < w; i++)
                exp_q.push_back(px({g[18*i+:6], 2'h0}, {g[18*i+6+:6], 2'h0}, {g[18*i+12+:6], 2'h0}, 1'b0));
    endtask

    task check_q;
        repeat (12) @(posedge hclk);
        `CHK("pixel count", exp_q.size(), got.size())
        for (int i = 0; i < exp_q.size() && i < got.size(); i++)
            `CHK("pixel", exp_q[i], got[i])
        exp_q.delete();
        got.delete();
    endtask

    initial
    begin
        #1000000;
        fails++;
        complete_run();
    end

    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, vpu_pkg::REG_CTRL, 32'h0);
        `CHK("ctrl reset", vpu_pkg::CTRL_RESET, rd)
        ahb(1'b0, vpu_pkg::REG_LINE_WIDTH, 32'h0);
        `CHK("width reset", {16'h0, vpu_pkg::LINE_WIDTH_RESET}, rd)
        ahb(1'b1, 8'h20, 32'hffff_ffff);
        ahb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        for (int i = 0; i < 8; i++)
        begin
            ahb(1'b1, vpu_pkg::REG_CTRL, {24'h0, pm[i]});
            host.send_frame(24'hc6a53b, 1'b1);
            par_expect(pm[i], 24'hc6a53b, 1'b1);
            host.send_frame(24'h395ac4, 1'b0);
            par_expect(pm[i], 24'h395ac4, 1'b0);
            check_q();
        end
        for (int i = 0; i < 4; i++)
        begin
            ahb(1'b1, vpu_pkg::REG_CTRL, {18'h0, pd[i], 8'h80});
            host.send_pkt(pg[i], nb[i]);
            pkt_expect(pd[i], pg[i], 4);
            check_q();
        end
        ahb(1'b0, vpu_pkg::REG_DROP_COUNT, 32'h0);
        d0 = rd;
        ahb(1'b1, vpu_pkg::REG_LINE_WIDTH, 32'h3);
        ahb(1'b1, vpu_pkg::REG_CTRL, {18'h0, vpu_pkg::DT_PACKED18, 8'h80});
        host.send_pkt(pg[1], 9);
        pkt_expect(vpu_pkg::DT_PACKED18, pg[1], 3);
        check_q();
        ahb(1'b0, vpu_pkg::REG_DROP_COUNT, 32'h0);
        `CHK("drop count", d0 + 32'h1, rd)
        complete_run();
    end
endmodule
